// ===== spp_pkg.sv
// Constants for the 6+2 pulse width modulator on the shared port D pin.
// Assumes a single 40 MHz system clock drives the whole block.
package spp_pkg;
  localparam int SPP_DUTY_W = 8;
  localparam int SPP_PERIOD_CLKS = 256;
  localparam int SPP_SUB_CLKS = 64;
  localparam logic [7:0] SPP_DUTY_RST = 8'h00;
  localparam logic [7:0] SPP_CNT_RST = 8'h00;
  localparam logic [7:0] SPP_CNT_LAST = 8'hFF;
  localparam int SPP_COARSE_LSB = 2;
  localparam int SPP_FINE_LSB = 0;
  localparam int SPP_SUB_LSB = 6;
endpackage

// ===== spp_pwm.sv
// Single channel 6+2 pulse width modulator with its port D bit 0 pin logic.
// Assumes the processor writes the duty register by a one-cycle strobe and
// that port D data, direction and the build option come from the same clock.
// Summary of operation
// - Full modulation period is 256 clocks, counted by an 8-bit counter.
// - Period splits into four 64-clock sub-cycles numbered 0 to 3.
// - Duty upper six bits are coarse count, lower two bits fine count.
// - Sub-cycles below fine count stay high coarse plus one clocks.
// - Counter advances on every system clock, no prescaler.
// - Sub-cycle spreading is done in hardware from one duty value.
// - Option on, pin output, data bit one routes waveform to pin.
// - Data bit zero drives the pin low; the raw waveform keeps running.
// - Option on with direction bit one leaves pin an ordinary input.
`timescale 1ns/1ps
`default_nettype none
module spp_pwm
  import spp_pkg::*;
(
  input wire logic clk, // System clock, 40 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic duty_value_we, // Write strobe for the duty register.
  input wire logic [7:0] duty_value_wdata, // Duty value being written.
  output logic [7:0] duty_value_rdata, // Duty register read back.
  input wire logic pwm_option_sel, // Build option selecting modulator use.
  input wire logic port_d_data_bit0, // Port D data bit 0, on/off control.
  input wire logic port_d_direction_bit0, // Port D direction bit 0, 1 = in.
  input wire logic shared_port_d_pin_zero_in, // Pin level, asynchronous.
  output logic shared_port_d_pin_zero_out, // Level driven onto the pin.
  output logic shared_port_d_pin_zero_oe_n, // Low while the pin is driven.
  output logic shared_port_d_pin_zero_pullup, // Pull-high enable in input.
  output logic pin_sync_in, // Synchronised pin level for the port.
  output logic duty_output_channel_zero // Raw modulator waveform.
);

  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] active;
    logic [7:0] cnt;
    logic wave;
    logic [1:0] sync;
  } spp_state_t;

  spp_state_t s_q;
  spp_state_t s_d;
  logic [5:0] coarse_duty_field;
  logic [1:0] fine_duty_field;
  logic [1:0] sub_idx;
  logic [5:0] sub_pos;
  logic [6:0] high_len;
  logic pin_drive;

  function automatic logic [6:0] spp_high_len(input logic [7:0] v,
                                              input logic [1:0] idx);
    spp_high_len = {1'b0, v[7:SPP_COARSE_LSB]} +
                   7'((idx < v[SPP_COARSE_LSB-1:SPP_FINE_LSB]) ? 1 : 0);
  endfunction

  assign coarse_duty_field = s_q.active[7:SPP_COARSE_LSB];
  assign fine_duty_field = s_q.active[SPP_COARSE_LSB-1:SPP_FINE_LSB];
  assign sub_idx = s_q.cnt[7:SPP_SUB_LSB];
  assign sub_pos = s_q.cnt[SPP_SUB_LSB-1:0];
  assign high_len = spp_high_len(s_q.active, sub_idx);

  always_comb begin
    s_d = s_q;
    s_d.cnt = 8'(s_q.cnt + 8'h01);
    s_d.wave = ({1'b0, sub_pos} < high_len);
    if (duty_value_we) begin
      s_d.duty = duty_value_wdata;
    end
    // The active copy reloads only at the period wrap so no period is torn.
    if (s_q.cnt == SPP_CNT_LAST) begin
      s_d.active = duty_value_we ? duty_value_wdata : s_q.duty;
    end
    s_d.sync = {s_q.sync[0], shared_port_d_pin_zero_in};
    if (srst) begin
      s_d.duty = SPP_DUTY_RST;
      s_d.active = SPP_DUTY_RST;
      s_d.cnt = SPP_CNT_RST;
      s_d.wave = 1'b0;
      s_d.sync = 2'b00;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign pin_drive = pwm_option_sel & ~port_d_direction_bit0;
  assign duty_value_rdata = s_q.duty;
  assign duty_output_channel_zero = s_q.wave;
  assign shared_port_d_pin_zero_oe_n = ~pin_drive;
  assign shared_port_d_pin_zero_out =
    pin_drive & port_d_data_bit0 & s_q.wave;
  assign shared_port_d_pin_zero_pullup = ~pin_drive;
  assign pin_sync_in = s_q.sync[1];

  property p_period_wrap;
    @(posedge clk) disable iff (srst)
      (s_q.cnt == SPP_CNT_LAST) |=> (s_q.cnt == SPP_CNT_RST);
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("Period counter did not wrap after 255.");

  property p_sub_start;
    @(posedge clk) disable iff (srst)
      (sub_pos == 6'h3F) |=> (sub_pos == 6'h00)
        && (sub_idx == $past(sub_idx) + 2'h1);
  endproperty
  a_sub_start: assert property (p_sub_start)
    else $error("Sub-cycle did not advance after 64 clocks.");

  property p_extra_clock;
    @(posedge clk) disable iff (srst)
      (sub_idx < fine_duty_field) && (sub_pos == coarse_duty_field)
      && (s_q.cnt != SPP_CNT_LAST) |=> s_q.wave;
  endproperty
  a_extra_clock: assert property (p_extra_clock)
    else $error("Extra high clock missing in early sub-cycle.");

  property p_plain_low;
    @(posedge clk) disable iff (srst)
      (sub_idx >= fine_duty_field) && (sub_pos == coarse_duty_field)
      && (s_q.cnt != SPP_CNT_LAST) |=> !s_q.wave;
  endproperty
  a_plain_low: assert property (p_plain_low)
    else $error("Output high past coarse count in late sub-cycle.");

  property p_hold_active;
    @(posedge clk) disable iff (srst)
      (s_q.cnt != SPP_CNT_LAST) |=> $stable(s_q.active);
  endproperty
  a_hold_active: assert property (p_hold_active)
    else $error("Active duty changed inside a period.");

  property p_load_active;
    @(posedge clk) disable iff (srst)
      (s_q.cnt == SPP_CNT_LAST) |=> (s_q.active == $past(s_d.duty));
  endproperty
  a_load_active: assert property (p_load_active)
    else $error("Duty not loaded at period start.");

  property p_off_low;
    @(posedge clk) disable iff (srst)
      !port_d_data_bit0 |-> !shared_port_d_pin_zero_out;
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("Pin not low while data bit 0 is clear.");

  property p_route;
    @(posedge clk) disable iff (srst)
      pwm_option_sel && !port_d_direction_bit0 && port_d_data_bit0 |->
        (shared_port_d_pin_zero_out == s_q.wave)
        && !shared_port_d_pin_zero_oe_n;
  endproperty
  a_route: assert property (p_route)
    else $error("Waveform not routed to the pin.");

  property p_input_mode;
    @(posedge clk) disable iff (srst)
      port_d_direction_bit0 |-> shared_port_d_pin_zero_oe_n
        && shared_port_d_pin_zero_pullup;
  endproperty
  a_input_mode: assert property (p_input_mode)
    else $error("Pin driven while direction bit 0 is set.");

  // Reset must leave the counter, waveform and duty register at rest.
  property p_reset_state;
    @(posedge clk)
      srst |=> (s_q.cnt == SPP_CNT_RST) && !s_q.wave
        && (duty_value_rdata == SPP_DUTY_RST);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("State not cleared by reset.");

  property p_count_step;
    @(posedge clk) disable iff (srst)
      (s_q.cnt != SPP_CNT_LAST) |=> (s_q.cnt == 8'($past(s_q.cnt) + 8'h01));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Period counter skipped or stalled.");

  property p_duty_write;
    @(posedge clk) disable iff (srst)
      duty_value_we |=> (duty_value_rdata == $past(duty_value_wdata));
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("Duty register did not take the written value.");

  // Any nonzero coarse count starts each sub-cycle high.
  property p_start_high;
    @(posedge clk) disable iff (srst)
      (sub_pos == 6'h00) && (coarse_duty_field != 6'h00) |=> s_q.wave;
  endproperty
  a_start_high: assert property (p_start_high)
    else $error("Sub-cycle did not start high.");

  property p_pull_off;
    @(posedge clk) disable iff (srst)
      !shared_port_d_pin_zero_oe_n |-> !shared_port_d_pin_zero_pullup;
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("Pull-high enabled while the pin is driven.");

  // The pin level reaches the port two clocks later, never sooner.
  property p_pin_sync;
    @(posedge clk) disable iff (srst)
      !$past(srst) && !$past(srst, 2) |->
        (pin_sync_in == $past(shared_port_d_pin_zero_in, 2));
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("Pin level not seen two clocks later.");

  c_fine_three: cover property (@(posedge clk) disable iff (srst)
    (fine_duty_field == 2'h3) && s_q.wave);
  c_reload: cover property (@(posedge clk) disable iff (srst)
    (s_q.cnt == SPP_CNT_LAST) && (s_q.duty != s_q.active));
  c_pin_high: cover property (@(posedge clk) disable iff (srst)
    shared_port_d_pin_zero_out);
  c_wave_off: cover property (@(posedge clk) disable iff (srst)
    !port_d_data_bit0 && s_q.wave);

endmodule
`default_nettype wire

// ===== spp_load.sv
// External load on the shared pin: resolves the pin and counts high clocks.
// Assumes the block's clock; clr restarts the count.
`timescale 1ns/1ps
`default_nettype none
module spp_load (
  input wire logic clk, // System clock.
  input wire logic clr, // Restart the count.
  input wire logic drv, // Level driven by the block.
  input wire logic oe_n, // Low while the block drives.
  input wire logic pull_en, // Pull-high enable.
  output logic pin, // Resolved pin level.
  output logic [8:0] hi_cnt // High clocks since clr.
);
  logic last_q;
  // A released pin without pull-high toggles, so no stale level is seen.
  assign pin = !oe_n ? drv : (pull_en | ~last_q);
  always_ff @(posedge clk) begin
    last_q <= pin;
    hi_cnt <= clr ? 9'h000 : hi_cnt + {8'h00, pin};
  end
endmodule
`default_nettype wire

// ===== spp_pwm_tb.sv
// Testbench for the 6+2 modulator: duty sweep, on/off and input mode.
// Assumes spp_load resolves the shared pin and counts its high clocks.
`timescale 1ns/1ps
`default_nettype none
module spp_pwm_tb
  import spp_pkg::*;
;
  logic clk, srst, we, opt, dat, dir, clr, pin, oe_n, pu, out, sync, raw;
  logic [7:0] wd, rd;
  logic [8:0] hi, n_hi;
  logic [7:0] dv [5] = '{8'h00, 8'h05, 8'hFF, 8'h7C, 8'h7E};
  int fails, total_checks;
  spp_pwm i_spp_pwm (.clk(clk), .srst(srst), .duty_value_we(we),
    .duty_value_wdata(wd), .duty_value_rdata(rd), .pwm_option_sel(opt),
    .port_d_data_bit0(dat), .port_d_direction_bit0(dir),
    .shared_port_d_pin_zero_in(pin), .shared_port_d_pin_zero_out(out),
    .shared_port_d_pin_zero_oe_n(oe_n), .shared_port_d_pin_zero_pullup(pu),
    .pin_sync_in(sync), .duty_output_channel_zero(raw));
  spp_load i_spp_load (.clk(clk), .clr(clr), .drv(out), .oe_n(oe_n),
    .pull_en(pu), .pin(pin), .hi_cnt(hi));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk) we <= 1'b1;
    wd <= d;
    @(posedge clk) we <= 1'b0;
    #1 chk({1'b0, rd}, {1'b0, d});
  endtask
  // Counts pin high clocks over n clocks through the load.
  task automatic meas(input int n, input logic [8:0] exp);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1 chk(hi, exp);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {srst, we, opt, dat, dir, clr, wd} = {1'b1, 5'h00, 8'h00};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    #1 chk({1'b0, rd}, {1'b0, SPP_DUTY_RST});
    // Option on and pin set as output before the waveform is expected.
    @(posedge clk) opt <= 1'b1;
    dir <= 1'b0;
    dat <= 1'b1;
    foreach (dv[i]) begin
      wr(dv[i]);
      repeat (512) @(posedge clk);
      meas(256, {1'b0, dv[i]});
      if (dv[i][1:0] == 2'h0)
        meas(64, {3'h0, dv[i][7:2]});
      $display("test duty %h done", dv[i]);
    end
    @(posedge clk) dat <= 1'b0;
    meas(256, 9'h000);
    chk({8'h00, oe_n}, 9'h000);
    chk({8'h00, pu}, 9'h000);
    chk({8'h00, sync}, 9'h000);
    // The raw waveform keeps running while the pin is held low.
    n_hi = 9'h000;
    repeat (256) begin
      @(posedge clk);
      #1 n_hi = n_hi + {8'h00, raw};
    end
    chk(n_hi, {1'b0, dv[4]});
    $display("test off done");
    @(posedge clk) dir <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({8'h00, oe_n}, 9'h001);
    chk({8'h00, pu}, 9'h001);
    chk({8'h00, sync}, 9'h001);
    $display("test input mode done");
    summarize();
  end
endmodule
`default_nettype wire
